// *** src/slmf_defs.vh ***
`ifndef SLMF_DEFS_VH
`define SLMF_DEFS_VH

// ****************************************
// timing
// ****************************************
`define SLMF_CLK_HZ          40000000
`define SLMF_SAMPLE_MS       2
// float time in clk_in cycles: 2 ms at 40 MHz, sized for the timer
`define SLMF_SAMPLE_CYCLES   17'h13880

// ****************************************
// register map (byte addresses)
// ****************************************
`define SLMF_ADDR_STATUS     4'h0
`define SLMF_ADDR_CTRL       4'h4

// status fields
`define SLMF_ST_FS_LSB       0
`define SLMF_ST_MODE_BIT     4
`define SLMF_ST_VALID_BIT    5
`define SLMF_ST_STATE_LSB    7

// control fields and reset value
`define SLMF_CTRL_MASK_W     12
`define SLMF_CTRL_RESET      12'h000

// ****************************************
// sequencer states
// ****************************************
`define SLMF_ST_IDLE         2'h0
`define SLMF_ST_SAMPLE       2'h1
`define SLMF_ST_CAPTURE      2'h2
`define SLMF_ST_RUN          2'h3

`endif

// *** src/slmf_sync.v ***
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser for asynchronous pin levels
module slmf_sync #(
   parameter WIDTH = 9
) (
   input  wire             clk_in,
   input  wire             rst_in,
   input  wire [WIDTH-1:0] d_in,
   output wire [WIDTH-1:0] q_out
);

   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   // first stage feeds only the second stage
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_reg <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
      end
   end

   assign q_out = sync_reg;

endmodule

`default_nettype wire

// *** src/slmf_top.v ***
`timescale 1ns/100ps
`default_nettype none
`include "slmf_defs.vh"

module slmf_top #(
   parameter [16:0] SAMPLE_CYCLES = `SLMF_SAMPLE_CYCLES
) (
   input  wire        clk_in,
   input  wire        rst_in,
   input  wire        supply_ok_in,
   input  wire [4:0]  strap_pin_in,
   output reg  [4:0]  strap_pin_out,
   output reg  [4:0]  strap_pin_oe_out,
   input  wire        pin2_in,
   output reg         pin2_out,
   output reg         pin2_oe_out,
   input  wire        clk_stop_n_in,
   input  wire        memclk_fanout_in,
   output wire [11:0] gated_memclk_outs_out,
   output reg         free_memclk_out,
   output reg         cpu_free_out,
   output reg         gated_processor_clock_out,
   output wire [3:0]  freq_select_straps_out,
   output wire        pin2_mode_out,
   output wire        strap_valid_out,
   input  wire [3:0]  avs_address_in,
   input  wire        avs_read_in,
   input  wire        avs_write_in,
   input  wire [31:0] avs_writedata_in,
   input  wire [3:0]  avs_byteenable_in,
   output reg  [31:0] avs_readdata_out,
   output wire        avs_waitrequest_out
);

   // ****************************************
   // state declarations
   // ****************************************
   localparam [1:0] ST_IDLE    = `SLMF_ST_IDLE;
   localparam [1:0] ST_SAMPLE  = `SLMF_ST_SAMPLE;
   localparam [1:0] ST_CAPTURE = `SLMF_ST_CAPTURE;
   localparam [1:0] ST_RUN     = `SLMF_ST_RUN;

   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg  [16:0] sample_cnt_reg;
   reg  [4:0]  strap_reg;
   reg         cpu_reg;
   reg  [1:0]  pci_cnt_reg;
   reg         pci_clk_reg;
   reg  [3:0]  div_cnt_reg;
   reg         cpu_stop_s1_reg;
   reg         cpu_en_reg;
   reg         mem_prev_reg;
   reg         mem_en_reg;
   reg  [11:0] mem_out_reg;
   reg         pstop_lat_reg;
   reg         pci_en_reg;
   reg  [11:0] mask_reg;
   reg         ack_reg;

   wire [8:0]  sync_q;
   wire [4:0]  strap_s;
   wire        pin2_s;
   wire        stop_n_s;
   wire        mem_s;
   wire        supply_s;
   wire        run;
   wire        mode;
   wire [3:0]  fs;
   wire        cpu_rise;
   wire        cpu_en_next;
   wire        mem_rise;
   wire        mem_en_next;
   wire [1:0]  pci_ratio;
   wire        pci_wrap;
   wire [1:0]  pci_cnt_next;
   wire        pci_rise;
   wire        pci_stop_n;
   wire        pci1_en_next;
   wire        req;
   wire [31:0] status_word;

   // ****************************************
   // pin synchronisers
   // ****************************************
   // every level from the board is asynchronous to clk_in
   slmf_sync #(
      .WIDTH (9)
   ) u_sync (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .d_in   ({supply_ok_in, memclk_fanout_in, clk_stop_n_in,
                pin2_in, strap_pin_in}),
      .q_out  (sync_q)
   );

   assign strap_s  = sync_q[4:0];
   assign pin2_s   = sync_q[5];
   assign stop_n_s = sync_q[6];
   assign mem_s    = sync_q[7];
   assign supply_s = sync_q[8];

   // ****************************************
   // power-up strap sequencer
   // ****************************************
   // rst_in stands for power removal; nothing else leaves RUN
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (supply_s)
               state_next = ST_SAMPLE;
         end
         ST_SAMPLE: begin
            if (sample_cnt_reg == SAMPLE_CYCLES - 17'h00001)
               state_next = ST_CAPTURE;
         end
         ST_CAPTURE: begin
            state_next = ST_RUN;
         end
         ST_RUN: begin
            state_next = ST_RUN;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // timer counts only while the pins float
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg      <= ST_IDLE;
         sample_cnt_reg <= 17'h00000;
      end else begin
         state_reg <= state_next;
         if (state_reg == ST_SAMPLE)
            sample_cnt_reg <= sample_cnt_reg + 17'h00001;
         else
            sample_cnt_reg <= 17'h00000;
      end
   end

   // capture happens one edge before any driver turns on
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in)
         strap_reg <= 5'h00;
      else if (state_reg == ST_CAPTURE)
         strap_reg <= strap_s;
   end

   assign run  = (state_reg == ST_RUN);
   // pin 7 gives the mode, pins 8,46,25,26 give fs3..fs0
   assign mode = strap_reg[0];
   assign fs   = {strap_reg[1], strap_reg[4], strap_reg[2], strap_reg[3]};
   assign freq_select_straps_out = run ? fs : 4'h0;
   assign pin2_mode_out          = run & mode;
   assign strap_valid_out        = run;

   // ****************************************
   // clock generation stand-ins
   // ****************************************
   // pci divide ratio per frequency select code
   function [1:0] ratio_of;
      input [3:0] code;
      begin
         case (code)
            4'hF, 4'hE, 4'hD, 4'hC: ratio_of = 2'h3;
            4'h3, 4'h2, 4'h1:       ratio_of = 2'h1;
            default:                ratio_of = 2'h2;
         endcase
      end
   endfunction

   // value is ratio minus one: processor/4, /3 or /2
   assign pci_ratio    = ratio_of(fs);
   assign cpu_rise     = ~cpu_reg;
   assign pci_wrap     = (pci_cnt_reg == pci_ratio);
   assign pci_cnt_next = pci_wrap ? 2'h0 : pci_cnt_reg + 2'h1;
   assign pci_rise     = cpu_rise & pci_wrap;

   // processor clock is clk_in/2; pci high for one processor period
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cpu_reg     <= 1'b0;
         pci_cnt_reg <= 2'h0;
         pci_clk_reg <= 1'b0;
         div_cnt_reg <= 4'h0;
      end else begin
         cpu_reg     <= ~cpu_reg;
         div_cnt_reg <= div_cnt_reg + 4'h1;
         if (cpu_rise) begin
            pci_cnt_reg <= pci_cnt_next;
            pci_clk_reg <= (pci_cnt_next == 2'h0);
         end
      end
   end

   // ****************************************
   // processor clock stop
   // ****************************************
   // enable moves only at a rising edge, so the clock stops low
   // after a whole period and restarts with a whole period
   assign cpu_en_next = cpu_rise ? cpu_stop_s1_reg : cpu_en_reg;

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cpu_stop_s1_reg           <= 1'b0;
         cpu_en_reg                <= 1'b0;
         cpu_free_out              <= 1'b0;
         gated_processor_clock_out <= 1'b0;
      end else begin
         if (cpu_rise)
            cpu_stop_s1_reg <= stop_n_s;
         cpu_en_reg   <= cpu_en_next;
         cpu_free_out <= run & cpu_rise;
         // enable changes only with cpu_rise, so the first period is never clipped
         gated_processor_clock_out <= run & cpu_rise & cpu_en_next;
      end
   end

   // ****************************************
   // memory clock fan-out
   // ****************************************
   // limitation: the copy is sampled, so memclk must stay well
   // below half of clk_in to be reproduced
   assign mem_rise    = mem_s & ~mem_prev_reg;
   assign mem_en_next = mem_rise ? stop_n_s : mem_en_reg;

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mem_prev_reg    <= 1'b0;
         mem_en_reg      <= 1'b0;
         free_memclk_out <= 1'b0;
      end else begin
         mem_prev_reg    <= mem_s;
         mem_en_reg      <= mem_en_next;
         free_memclk_out <= mem_s;
      end
   end

   // one gated copy per output; a mask bit holds its copy low
   genvar g;
   generate
      for (g = 0; g < 12; g = g + 1) begin : g_mem
         always @(posedge clk_in or posedge rst_in) begin
            if (rst_in)
               mem_out_reg[g] <= 1'b0;
            else
               mem_out_reg[g] <= mem_s & mem_en_next & ~mask_reg[g];
         end
      end
   endgenerate

   assign gated_memclk_outs_out = mem_out_reg;

   // ****************************************
   // pin 2 and pci stop
   // ****************************************
   // as a reference output pin 2 cannot stop anything
   assign pci_stop_n   = (run & ~mode) ? pin2_s : 1'b1;
   assign pci1_en_next = pci_rise ? pstop_lat_reg : pci_en_reg;

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pstop_lat_reg <= 1'b1;
         pci_en_reg    <= 1'b1;
      end else if (pci_rise) begin
         pstop_lat_reg <= pci_stop_n;
         pci_en_reg    <= pstop_lat_reg;
      end
   end

   // ****************************************
   // dual-purpose pin drivers
   // ****************************************
   // bit order: pin7 pci_f, pin8 pci1, pin25 24m, pin26 48m, pin46 ref1
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         strap_pin_out    <= 5'h00;
         strap_pin_oe_out <= 5'h00;
         pin2_out         <= 1'b0;
         pin2_oe_out      <= 1'b0;
      end else begin
         if (run) begin
            strap_pin_oe_out <= 5'h1F;
            strap_pin_out    <= {div_cnt_reg[2], div_cnt_reg[0],
                                 div_cnt_reg[1],
                                 pci_clk_reg & pci1_en_next,
                                 pci_clk_reg};
         end else begin
            strap_pin_oe_out <= 5'h00;
            strap_pin_out    <= 5'h00;
         end
         pin2_oe_out <= run & mode;
         pin2_out    <= run & mode & div_cnt_reg[2];
      end
   end

   // ****************************************
   // avalon-mm register slave
   // ****************************************
   // one wait cycle per access keeps the read path registered
   assign req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~ack_reg;

   assign status_word = {23'h000000, state_reg, 1'b0, run,
                         run & mode, run ? fs : 4'h0};

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_reg          <= 1'b0;
         mask_reg         <= `SLMF_CTRL_RESET;
         avs_readdata_out <= 32'h00000000;
      end else begin
         ack_reg <= req & ~ack_reg;
         if (avs_read_in & ~ack_reg) begin
            case (avs_address_in)
               `SLMF_ADDR_STATUS: avs_readdata_out <= status_word;
               `SLMF_ADDR_CTRL:
                  avs_readdata_out <= {20'h00000, mask_reg};
               default:           avs_readdata_out <= 32'h00000000;
            endcase
         end
         if (avs_write_in & ack_reg &
             (avs_address_in == `SLMF_ADDR_CTRL)) begin
            if (avs_byteenable_in[0])
               mask_reg[7:0] <= avs_writedata_in[7:0];
            if (avs_byteenable_in[1])
               mask_reg[11:8] <= avs_writedata_in[11:8];
         end
      end
   end

endmodule

`default_nettype wire

// *** verification/slmf_board.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// strap resistors and chipset stop driver
// ****************************************
module slmf_board (
   input  wire logic [4:0] lvl_in,
   input  wire logic [4:0] drv_in,
   input  wire logic [4:0] oe_in,
   input  wire logic       stop_n_in,
   input  wire logic       p2_drv_in,
   input  wire logic       p2_oe_in,
   output wire logic [4:0] pin_out,
   output wire logic       p2_out
);
   // a weak strap loses to any enabled driver
   assign pin_out = (oe_in & drv_in) | (~oe_in & lvl_in);
   // chipset owns pin 2 only while the device floats it
   assign p2_out = p2_oe_in ? p2_drv_in : stop_n_in;
endmodule
`default_nettype wire

// *** verification/slmf_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module slmf_properties #(
   parameter [16:0] SAMPLE_CYCLES = 17'd20
) (
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic [4:0]  strap_pin_in,
   input wire logic [4:0]  strap_pin_oe_out,
   input wire logic        clk_stop_n_in,
   input wire logic        memclk_fanout_in,
   input wire logic [11:0] gated_memclk_outs_out,
   input wire logic        free_memclk_out,
   input wire logic        gated_processor_clock_out,
   input wire logic [3:0]  freq_select_straps_out,
   input wire logic        pin2_mode_out,
   input wire logic        strap_valid_out
);
   logic [4:0] stop_cnt;
   wire  [4:0] pin_ord = {strap_pin_in[1], strap_pin_in[4], strap_pin_in[2],
                          strap_pin_in[3], strap_pin_in[0]};
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // ****************************************
   // stop length and checks
   // ****************************************
   // saturates so a long stop never wraps back to a short one
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         stop_cnt <= 5'h00;
      end else if (clk_stop_n_in) begin
         stop_cnt <= 5'h00;
      end else if (stop_cnt != 5'h1F) begin
         stop_cnt <= stop_cnt + 5'h01;
      end
   end
   a_float_early: assert property (
      !strap_valid_out |-> strap_pin_oe_out == 5'h00)
      else $error("strap pin driven early");
   a_drive_after: assert property (
      $rose(strap_valid_out) |-> ##[0:1] strap_pin_oe_out == 5'h1F)
      else $error("strap pins not driven");
   a_capture_level: assert property (
      $rose(strap_valid_out) |->
      {freq_select_straps_out, pin2_mode_out} == $past(pin_ord, 3))
      else $error("captured level wrong");
   a_straps_held: assert property (
      strap_valid_out |=> strap_valid_out && $stable(pin2_mode_out)
      && $stable(freq_select_straps_out))
      else $error("straps changed");
   a_straps_hidden: assert property (
      !strap_valid_out |-> freq_select_straps_out == 4'h0 && !pin2_mode_out)
      else $error("straps shown early");
   a_gated_off: assert property (
      stop_cnt >= 5'h18 |-> gated_memclk_outs_out == 12'h000)
      else $error("gated memclk not off");
   a_cpu_stop: assert property (
      stop_cnt >= 5'h18 |-> !gated_processor_clock_out)
      else $error("processor clock not stopped");
   a_free_copy: assert property (
      $stable(memclk_fanout_in)[*6] |-> free_memclk_out == memclk_fanout_in)
      else $error("free memclk not a copy");
   c_run_ref: cover property ($rose(strap_valid_out) && pin2_mode_out);
   c_run_stop: cover property ($rose(strap_valid_out) && !pin2_mode_out);
   c_long_stop: cover property (stop_cnt == 5'h18);
endmodule
bind slmf_top slmf_properties #(.SAMPLE_CYCLES(SAMPLE_CYCLES))
   i_slmf_properties (.clk_in(clk_in), .rst_in(rst_in),
   .strap_pin_in(strap_pin_in), .strap_pin_oe_out(strap_pin_oe_out),
   .clk_stop_n_in(clk_stop_n_in), .memclk_fanout_in(memclk_fanout_in),
   .gated_memclk_outs_out(gated_memclk_outs_out),
   .free_memclk_out(free_memclk_out),
   .gated_processor_clock_out(gated_processor_clock_out),
   .freq_select_straps_out(freq_select_straps_out),
   .pin2_mode_out(pin2_mode_out), .strap_valid_out(strap_valid_out));
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        sup = 1'b0;
   logic [4:0]  lvl = 5'h00;
   logic        pstop_n = 1'b1;
   logic        cstop_n = 1'b1;
   logic [3:0]  mc = 4'h0;
   logic [3:0]  adr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [3:0]  be = 4'h0;
   wire  [4:0]  pw, pq, poe;
   wire         p2w, p2q, p2oe, fm, cf, cg, mode, vld, wt;
   wire  [11:0] gm;
   wire  [3:0]  fs;
   wire  [31:0] rdat;
   int          err_count = 0;
   int          num_checks = 0;
   int          h[10]; // highs: mem, misses, cpu, pci, pin2, stand-ins
   // ****************************************
   // clocks, parts and tasks
   // ****************************************
   initial begin
      forever #12.5 clk_in = ~clk_in;
   end
   // memclk at a sixteenth of the system rate, well below the copy limit
   always @(posedge clk_in) begin
      mc <= mc + 4'h1;
   end
   slmf_top #(.SAMPLE_CYCLES(17'd20)) i_slmf_top (
      .clk_in(clk_in), .rst_in(rst_in), .supply_ok_in(sup),
      .strap_pin_in(pw), .strap_pin_out(pq), .strap_pin_oe_out(poe),
      .pin2_in(p2w), .pin2_out(p2q), .pin2_oe_out(p2oe),
      .clk_stop_n_in(cstop_n), .memclk_fanout_in(mc[3]),
      .gated_memclk_outs_out(gm), .free_memclk_out(fm),
      .cpu_free_out(cf), .gated_processor_clock_out(cg),
      .freq_select_straps_out(fs), .pin2_mode_out(mode),
      .strap_valid_out(vld), .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wt));
   slmf_board i_slmf_board (.lvl_in(lvl), .drv_in(pq), .oe_in(poe),
      .stop_n_in(pstop_n), .p2_drv_in(p2q), .p2_oe_in(p2oe),
      .pin_out(pw), .p2_out(p2w));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic tmo;
      err_count++;
      $display("Error at %0t wait ran out got %h exp %h", $time, 0, 1);
      end_sim();
   endtask
   // a running clock is high for some but not all of a window
   function automatic logic run(input int x);
      return x > 8 && x < 56;
   endfunction
   function automatic logic [3:0] fso(input logic [4:0] s);
      return {s[1], s[4], s[2], s[3]};
   endfunction
   // one bus access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a,
         input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_in);
      adr <= a;
      wr <= w;
      rd <= ~w;
      wd <= d;
      be <= b;
      do begin
         @(posedge clk_in);
         n++;
      end while (wt !== 1'b0 && n < 20);
      if (n >= 20) tmo();
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic watch(input logic [11:0] m);
      h = '{10{0}};
      repeat (64) begin
         @(posedge clk_in);
         h[0] += fm;
         h[1] += (gm !== ({12{fm}} & ~m));
         h[2] += cg;
         h[3] += cf;
         h[4] += pq[0];
         h[5] += pq[1];
         h[6] += p2q;
         h[7] += pq[2];
         h[8] += pq[3];
         h[9] += pq[4];
      end
   endtask
   task automatic t_power(input logic [4:0] s);
      int n;
      rst_in <= 1'b1;
      sup <= 1'b0;
      lvl <= s;
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (10) @(posedge clk_in);
      chk(vld, 1'b0);
      sup <= 1'b1;
      n = 0;
      while (vld !== 1'b1 && n < 200) begin
         @(posedge clk_in);
         n++;
         if (vld !== 1'b1) chk(poe, 5'h00);
      end
      if (n >= 200) tmo();
      chk(n >= 20 && n <= 28, 1'b1);
      chk(fs, fso(s));
      chk(mode, s[0]);
      repeat (2) @(posedge clk_in);
      chk(poe, 5'h1F);
      chk(p2oe, s[0]);
      $display("power-up done");
   endtask
   task automatic t_regs(input logic [4:0] s);
      logic [31:0] q;
      bus(1'b0, 4'h4, 32'h0, 4'hF, q);
      chk(q, 32'h0);
      bus(1'b1, 4'h4, 32'hABC, 4'hF, q);
      bus(1'b1, 4'h4, 32'hFFF, 4'h1, q);
      bus(1'b0, 4'h4, 32'h0, 4'hF, q);
      chk(q, 32'hAFF);
      bus(1'b1, 4'h0, 32'hFFFF, 4'hF, q);
      bus(1'b0, 4'h0, 32'h0, 4'hF, q);
      chk(q, {23'h0, 2'h3, 1'b0, 1'b1, s[0], fso(s)});
      bus(1'b0, 4'h8, 32'h0, 4'hF, q);
      chk(q, 32'h0);
      $display("registers done");
   endtask
   task automatic t_mem;
      logic [31:0] q;
      repeat (30) @(posedge clk_in);
      watch(12'hAFF);
      chk(h[1], 0);
      bus(1'b1, 4'h4, 32'h0, 4'hF, q);
      repeat (30) @(posedge clk_in);
      watch(12'h000);
      chk(h[1], 0);
      chk(run(h[0]), 1'b1);
      chk(run(h[2]), 1'b1);
      // straps 1B select processor/4: pci high 2 of every 8 cycles
      chk(h[4] >= 14 && h[4] <= 18, 1'b1);
      chk(run(h[6]), 1'b1);
      chk(run(h[7]) & run(h[8]) & run(h[9]), 1'b1);
      cstop_n <= 1'b0;
      repeat (30) @(posedge clk_in);
      watch(12'hFFF);
      chk(h[1], 0);
      chk(run(h[0]), 1'b1);
      chk(h[2], 0);
      chk(run(h[3]), 1'b1);
      cstop_n <= 1'b1;
      repeat (30) @(posedge clk_in);
      watch(12'h000);
      chk(run(h[2]), 1'b1);
      chk(h[1], 0);
      $display("clock gating done");
   endtask
   // supply dropping after capture must not clear or resample
   task automatic t_hold(input logic [4:0] s);
      lvl <= ~s;
      sup <= 1'b0;
      repeat (30) @(posedge clk_in);
      chk(vld, 1'b1);
      chk(fs, fso(s));
      sup <= 1'b1;
      $display("hold done");
   endtask
   task automatic t_pci;
      pstop_n <= 1'b0;
      repeat (30) @(posedge clk_in);
      watch(12'h000);
      chk(h[5], 0);
      chk(run(h[4]), 1'b1);
      // straps 04 select processor/2: pci high 2 of every 4 cycles
      chk(h[4] >= 30 && h[4] <= 34, 1'b1);
      chk(h[6], 0);
      pstop_n <= 1'b1;
      repeat (30) @(posedge clk_in);
      watch(12'h000);
      chk(run(h[5]), 1'b1);
      $display("pci stop done");
   endtask
   initial begin
      t_power(5'h1B);
      t_regs(5'h1B);
      t_mem();
      t_hold(5'h1B);
      t_power(5'h04);
      t_pci();
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      tmo();
   end
endmodule
`default_nettype wire
